// ==== verilog/lcdd_top.sv ====
// Instruction decoder of a one-line character LCD controller with serial host port.
// Assumes an APB master on clk and a serial host on its own clock sclk.
//
// Overview of operation
// - 0000_1DCB sets display, cursor, blink enables
// - Display off blanks panel, RAM kept
// - Cursor is five dots on line eight
// - Blink cursor character, 540 ms period
// - 0001_SR** is cursor or display shift
// - Cursor shift steps address counter by one
// - Display shift moves window, counter unchanged
// - 1AAA_AAAA loads the address counter
// - Address picks display, glyph or icon RAM
// - Status read gives busy and address counter
// - Data write steps counter, optional display shift
// - Data read steps counter, never shifts display
// - Cursor shift refreshes display RAM read data
// - Display shift never alters display RAM
// - MSB first, rise in, fall out, CS latch
// - Entry direction one increments, zero decrements
`timescale 1ns/1ps
module lcdd_top
  import lcdd_pkg::*;
#(
  parameter int BUSY_CYCLES = EXEC_CYC,
  parameter int BLINK_CYC   = BLINK_HALF
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial host link
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  input  wire logic        register_select,
  input  wire logic        read_not_write,
  output logic             sdo_o,
  output logic             sdo_oe,
  // Panel scan
  input  wire logic [3:0]  scan_col,
  input  wire logic [2:0]  scan_line,
  output lcdd_scan_t       scan_q
);

  if (BUSY_CYCLES < 1 || BLINK_CYC < 1) begin : g_bad_counts
    $error("lcdd_top: counts must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: shift in on rising sclk, out on falling sclk
  logic [7:0] rx_q;
  logic [2:0] bit_q;
  logic [7:0] tx_q;

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      rx_q <= 8'h00;
    end else if (!cs_n) begin
      rx_q <= {rx_q[6:0], sdi};
    end
  end

  // Frame end clears the bit pointer, so no sclk edge is needed after a frame
  always_ff @(negedge sclk or posedge cs_n or posedge rst) begin
    if (rst || cs_n) begin
      bit_q <= 3'h0;
    end else begin
      bit_q <= bit_q + 3'h1;
    end
  end

  assign sdo_o = tx_q[3'h7 - bit_q];

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into clk: two flops per pin level
  logic [2:0] cs_sync_q;
  logic [1:0] sel_sync_q;
  logic [1:0] rw_sync_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_sync_q <= 3'b111;
      sel_sync_q <= 2'b00;
      rw_sync_q <= 2'b00;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], cs_n};
      sel_sync_q <= {sel_sync_q[0], register_select};
      rw_sync_q <= {rw_sync_q[0], read_not_write};
    end
  end

  logic cs_s;
  logic cs_rise;
  assign cs_s    = cs_sync_q[1];
  assign cs_rise = cs_sync_q[1] && !cs_sync_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Decoder state
  logic [31:0]  ctrl_q;
  lcdd_mode_t   mode_q;
  logic [6:0]   addr_q;
  logic [3:0]   ofs_q;
  logic         busy_q;
  logic [31:0]  busy_cnt_q;
  logic [7:0]   rd_latch_q;
  logic         fetch_q;
  lcdd_cmd_t    last_q;
  logic [7:0]   dd_q [DD_CHARS];
  logic [4:0]   cg_q [32];
  logic [4:0]   mk_q [5];

  lcdd_cmd_t cmd;
  logic      accept;
  assign cmd    = '{dsel: sel_sync_q[1], rw: rw_sync_q[1], code: rx_q};
  // rx_q is stable once cs has risen: sclk stays idle between frames
  assign accept = cs_rise && !busy_q && ctrl_q[0];

  logic is_clear, is_home, is_entry, is_disp, is_shift, is_seta;
  logic is_dwr, is_drd;
  always_comb begin
    is_clear = accept && !cmd.dsel && !cmd.rw && cmd.code == CMD_CLEAR;
    is_home  = accept && !cmd.dsel && !cmd.rw && cmd.code[7:2] == 6'h00 && cmd.code[BIT_HOME];
    is_entry = accept && !cmd.dsel && !cmd.rw && cmd.code[7:3] == 5'h00 && cmd.code[BIT_ENTRY];
    is_disp  = accept && !cmd.dsel && !cmd.rw && cmd.code[7:4] == 4'h0 && cmd.code[BIT_DISP];
    is_shift = accept && !cmd.dsel && !cmd.rw && cmd.code[7:5] == 3'h0 && cmd.code[BIT_SHIFT];
    is_seta  = accept && !cmd.dsel && !cmd.rw && cmd.code[BIT_SETADR];
    is_dwr   = accept && cmd.dsel && !cmd.rw;
    is_drd   = accept && cmd.dsel && cmd.rw;
  end

  function automatic logic [6:0] step(input logic [6:0] a, input logic up);
    step = up ? a + 7'h01 : a - 7'h01;
  endfunction

  function automatic logic [3:0] wstep(input logic [3:0] o, input logic left);
    if (left) wstep = (o == 4'(DD_CHARS - 1)) ? 4'h0 : o + 4'h1;
    else      wstep = (o == 4'h0) ? 4'(DD_CHARS - 1) : o - 4'h1;
  endfunction

  function automatic logic [7:0] ram_rd(input logic [6:0] a);
    ram_rd = 8'h00;
    if (a <= DD_LAST)                         ram_rd = dd_q[a[3:0]];
    else if (a >= CG_FIRST && a <= CG_LAST)   ram_rd = {3'b000, cg_q[a[4:0]]};
    else if (a >= MK_FIRST && a <= MK_LAST)   ram_rd = {3'b000, mk_q[a[2:0]]};
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= '{display_en: 1'b0, cursor_en: 1'b0, blink_en: 1'b0,
                  incr: 1'b1, entry_shift: 1'b0};
    end else if (is_disp) begin
      mode_q.display_en <= cmd.code[2];
      mode_q.cursor_en  <= cmd.code[1];
      mode_q.blink_en   <= cmd.code[0];
    end else if (is_entry) begin
      mode_q.incr        <= cmd.code[1];
      mode_q.entry_shift <= cmd.code[0];
    end else if (is_clear) begin
      mode_q.incr <= 1'b1;
    end
  end

  // Address counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q <= 7'h00;
    end else if (is_clear || is_home) begin
      addr_q <= 7'h00;
    end else if (is_seta) begin
      addr_q <= cmd.code[6:0];
    end else if (is_shift && !cmd.code[3]) begin
      addr_q <= step(addr_q, cmd.code[2]);
    end else if (is_dwr || is_drd) begin
      addr_q <= step(addr_q, mode_q.incr);
    end
  end

  // Window offset; display RAM is never touched here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ofs_q <= 4'h0;
    end else if (is_clear || is_home) begin
      ofs_q <= 4'h0;
    end else if (is_shift && cmd.code[3]) begin
      ofs_q <= wstep(ofs_q, !cmd.code[2]);
    end else if (is_dwr && mode_q.entry_shift && addr_q <= DD_LAST) begin
      ofs_q <= wstep(ofs_q, mode_q.incr);
    end
  end

  // Display RAM, one entry per generate step
  for (genvar i = 0; i < DD_CHARS; i++) begin : g_dd
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        dd_q[i] <= CHAR_SPACE;
      end else if (is_clear) begin
        dd_q[i] <= CHAR_SPACE;
      end else if (is_dwr && addr_q == 7'(i)) begin
        dd_q[i] <= cmd.code;
      end
    end
  end

  // Glyph and icon RAM cleared, so early reads never carry unknowns
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int j = 0; j < 32; j++) cg_q[j] <= 5'h00;
      for (int j = 0; j < 5; j++) mk_q[j] <= 5'h00;
    end else begin
      if (is_dwr && addr_q >= CG_FIRST && addr_q <= CG_LAST) begin
        cg_q[addr_q[4:0]] <= cmd.code[4:0];
      end
      if (is_dwr && addr_q >= MK_FIRST && addr_q <= MK_LAST) begin
        mk_q[addr_q[2:0]] <= cmd.code[4:0];
      end
    end
  end

  // Read latch: refreshed after an address set, cursor shift or data read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fetch_q    <= 1'b0;
      rd_latch_q <= 8'h00;
    end else begin
      fetch_q <= is_seta || is_drd || (is_shift && !cmd.code[3]);
      if (fetch_q) begin
        rd_latch_q <= ram_rd(addr_q);
      end
    end
  end

  // Busy window after each accepted instruction or data access except a status read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt_q <= 32'h0000_0000;
      busy_q     <= 1'b0;
    end else if (accept && !(!cmd.dsel && cmd.rw)) begin
      busy_cnt_q <= 32'(BUSY_CYCLES - 1);
      busy_q     <= 1'b1;
    end else if (busy_cnt_q != 32'h0000_0000) begin
      busy_cnt_q <= busy_cnt_q - 32'h0000_0001;
    end else begin
      busy_q <= 1'b0;
    end
  end

  // Outgoing byte, frozen while a frame is open
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_q   <= 8'h00;
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= !cs_s && rw_sync_q[1];
      if (cs_s) begin
        tx_q <= sel_sync_q[1] ? rd_latch_q : {busy_q, addr_q};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q <= '0;
    end else if (accept) begin
      last_q <= cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blink phase and panel scan
  logic [31:0] blink_cnt_q;
  logic        blink_ph_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_ph_q  <= 1'b0;
    end else if (blink_cnt_q == 32'(BLINK_CYC - 1)) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_ph_q  <= !blink_ph_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  logic [4:0] sum;
  logic [3:0] ram_col;
  logic       at_cursor;
  always_comb begin
    sum       = 5'(scan_col) + 5'(ofs_q);
    ram_col   = (sum >= 5'(DD_CHARS)) ? 4'(sum - 5'(DD_CHARS)) : sum[3:0];
    at_cursor = (addr_q <= DD_LAST) && (addr_q[3:0] == ram_col);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_q <= '0;
    end else begin
      scan_q.char_code <= (scan_col < 4'(DD_CHARS)) ? dd_q[ram_col] : CHAR_SPACE;
      scan_q.blank     <= !mode_q.display_en;
      if (at_cursor && mode_q.blink_en && blink_ph_q) begin
        scan_q.overlay <= 5'h1F;
      end else if (at_cursor && mode_q.cursor_en && scan_line == 3'(CURSOR_LINE)) begin
        scan_q.overlay <= 5'h1F;
      end else begin
        scan_q.overlay <= 5'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  logic apb_setup;
  assign apb_setup = psel && !penable;
  assign pready    = 1'b1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q  <= CTRL_RESET;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      unique case (paddr)
        OFS_CTRL:    prdata <= ctrl_q;
        OFS_STATUS:  prdata <= {12'h000, ofs_q, busy_q, addr_q, 3'b000,
                                mode_q.display_en, mode_q.cursor_en, mode_q.blink_en,
                                mode_q.incr, mode_q.entry_shift};
        OFS_LASTCMD: prdata <= {22'h00_0000, last_q};
        default:     pslverr <= 1'b1;
      endcase
    end else if (psel && penable && pwrite && paddr == OFS_CTRL) begin
      ctrl_q <= {31'h0000_0000, pwdata[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_disp_decode: assert property (@(posedge clk) disable iff (rst)
    is_disp |=> mode_q.display_en == $past(cmd.code[2]) && mode_q.cursor_en == $past(cmd.code[1])
                && mode_q.blink_en == $past(cmd.code[0]))
    else $error("display control not decoded");
  a_blank_off: assert property (@(posedge clk) disable iff (rst)
    !mode_q.display_en ##1 !mode_q.display_en |-> scan_q.blank)
    else $error("panel not blanked");
  a_cursor_move: assert property (@(posedge clk) disable iff (rst)
    is_shift && !cmd.code[3] |=> addr_q == step($past(addr_q), $past(cmd.code[2])))
    else $error("cursor shift wrong");
  a_window_shift: assert property (@(posedge clk) disable iff (rst)
    is_shift && cmd.code[3] |=> $stable(addr_q) && !$stable(ofs_q))
    else $error("display shift wrong");
  a_addr_load: assert property (@(posedge clk) disable iff (rst)
    is_seta |=> addr_q == $past(cmd.code[6:0]) ##1 rd_latch_q == ram_rd(addr_q))
    else $error("address set wrong");
  a_status_byte: assert property (@(posedge clk) disable iff (rst)
    cs_s && !sel_sync_q[1] |=> tx_q == {$past(busy_q), $past(addr_q)})
    else $error("status byte wrong");
  a_write_step: assert property (@(posedge clk) disable iff (rst)
    is_dwr |=> addr_q == step($past(addr_q), $past(mode_q.incr)) && busy_q)
    else $error("write step wrong");
  a_read_noshift: assert property (@(posedge clk) disable iff (rst)
    is_drd |=> $stable(ofs_q) && addr_q == step($past(addr_q), $past(mode_q.incr)))
    else $error("read shifted display");
  a_busy_refuse: assert property (@(posedge clk) disable iff (rst)
    cs_rise && busy_q |=> $stable(addr_q) && $stable(mode_q))
    else $error("command taken while busy");

  c_status_read: cover property (@(posedge clk) disable iff (rst) accept && !cmd.dsel && cmd.rw);
  c_data_write:  cover property (@(posedge clk) disable iff (rst) is_dwr);
  c_data_read:   cover property (@(posedge clk) disable iff (rst) is_drd);
  c_disp_shift:  cover property (@(posedge clk) disable iff (rst) is_shift && cmd.code[3]);

endmodule : lcdd_top

// ==== verilog/lcdd_pkg.sv ====
// Package for the character LCD instruction decoder.
// Assumes a 200 MHz system clock and a separate serial link clock.
package lcdd_pkg;

  // System clock and timing
  localparam int CLK_MHZ      = 200;
  localparam int EXEC_US      = 223;
  localparam int BLINK_MS     = 540;
  localparam int EXEC_CYC     = EXEC_US * CLK_MHZ;
  localparam int BLINK_HALF   = BLINK_MS * 1000 * CLK_MHZ / 2;

  // Instruction codes and fields
  localparam logic [7:0] CMD_CLEAR   = 8'h01;
  localparam int         BIT_HOME    = 1;
  localparam int         BIT_ENTRY   = 2;
  localparam int         BIT_DISP    = 3;
  localparam int         BIT_SHIFT   = 4;
  localparam int         BIT_SETADR  = 7;
  localparam logic [7:0] CHAR_SPACE  = 8'h20;

  // RAM map
  localparam int         DD_CHARS    = 12;
  localparam logic [6:0] DD_LAST     = 7'h0B;
  localparam logic [6:0] CG_FIRST    = 7'h40;
  localparam logic [6:0] CG_LAST     = 7'h5F;
  localparam logic [6:0] MK_FIRST    = 7'h60;
  localparam logic [6:0] MK_LAST     = 7'h64;
  localparam int         CURSOR_LINE = 7;

  // APB register map
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_STATUS  = 12'h004;
  localparam logic [11:0] OFS_LASTCMD = 12'h008;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;

  typedef struct packed {
    logic       dsel;
    logic       rw;
    logic [7:0] code;
  } lcdd_cmd_t;

  typedef struct packed {
    logic [7:0] char_code;
    logic       blank;
    logic [4:0] overlay;
  } lcdd_scan_t;

  typedef struct packed {
    logic       display_en;
    logic       cursor_en;
    logic       blink_en;
    logic       incr;
    logic       entry_shift;
  } lcdd_mode_t;

endpackage : lcdd_pkg

// ==== verif/lcdd_host_model.sv ====
// Host model driving the serial instruction port of the LCD decoder.
// Assumes one task call at a time; the link clock runs only inside frames.
`timescale 1ns/1ps
module lcdd_host_model (
  input  wire logic sdo_o,
  input  wire logic sdo_oe,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  output logic      register_select,
  output logic      read_not_write
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    register_select = 1'b1;
    read_not_write = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One frame, 32 ns link period, MSB first
  task automatic xfer(input logic dsel, input logic rw, input logic [7:0] tx,
                      output logic [7:0] rx);
    register_select = dsel;
    read_not_write = rw;
    #20;
    cs_n = 1'b0;
    #32;
    for (int i = 7; i >= 0; i--) begin
      sdi = tx[i];
      #16;
      sclk = 1'b1;
      // Undriven data line reads as the inverse
      rx[i] = sdo_oe ? sdo_o : ~sdo_o;
      #16;
      sclk = 1'b0;
    end
    #16;
    cs_n = 1'b1;
    #20;
    // Released lines: pull-ups to 1, data line inverted
    sdi = ~sdi;
    register_select = 1'b1;
    read_not_write = 1'b1;
    #20;
  endtask : xfer

  ////////////////////////////////////////////////////////////////////////////
  // Poll busy until clear, bounded
  task automatic ready(output logic ok, output logic [7:0] st);
    ok = 1'b0;
    for (int n = 0; n < 40 && !ok; n++) begin
      xfer(1'b0, 1'b1, 8'h00, st);
      ok = (st[7] === 1'b0);
    end
  endtask : ready
endmodule : lcdd_host_model

// ==== verif/lcdd_top_tb.sv ====
// Self-checking bench for the LCD instruction decoder.
// Assumes lcdd_pkg and lcdd_top compiled first; host model drives the link.
`timescale 1ns/1ps
module lcdd_top_tb
  import lcdd_pkg::*;
;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        sclk, cs_n, sdi, rsel, rnw, sdo_o, sdo_oe;
  logic [3:0]  scan_col;
  logic [2:0]  scan_line;
  lcdd_scan_t  scan_q;
  int          checks = 0;
  int          fail_count = 0;

  lcdd_top #(.BUSY_CYCLES(100), .BLINK_CYC(8)) uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .register_select(rsel), .read_not_write(rnw), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .scan_col(scan_col), .scan_line(scan_line), .scan_q(scan_q));

  lcdd_host_model host (
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .register_select(rsel), .read_not_write(rnw));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      results();
    end
  endtask : apb

  task automatic stat(output logic [31:0] s);
    logic e;
    apb(1'b0, OFS_STATUS, 32'h0000_0000, s, e);
  endtask : stat

  // Serial transfer, then wait for busy clear
  task automatic op(input logic dsel, input logic rw, input logic [7:0] c,
                    output logic [7:0] d);
    logic       ok;
    logic [7:0] st;
    host.xfer(dsel, rw, c, d);
    host.ready(ok, st);
    if (ok !== 1'b1) begin
      fail_count++;
      results();
    end
  endtask : op

  task automatic scan(input logic [3:0] c, input logic [2:0] l, output lcdd_scan_t s);
    @(posedge clk);
    scan_col <= c;
    scan_line <= l;
    repeat (3) @(posedge clk);
    s = scan_q;
  endtask : scan

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    lcdd_scan_t  s;
    apb(1'b0, OFS_CTRL, 32'h0000_0000, r, e);
    check(r, CTRL_RESET);
    stat(r);
    check(r, 32'h0000_0002);
    apb(1'b0, 12'h00C, 32'h0000_0000, r, e);
    check({r[30:0], e}, 32'h0000_0001);
    apb(1'b1, 12'h010, 32'h0000_0005, r, e);
    check(32'(e), 32'h0000_0001);
    scan(4'h0, 3'h0, s);
    check(32'({s.char_code, s.blank}), 32'h0000_0041);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_ctrl;
    logic [7:0]  d;
    logic [31:0] s;
    op(1'b0, 1'b0, 8'h06, d);
    for (int k = 0; k < 8; k++) begin
      op(1'b0, 1'b0, 8'(8'h08 + k), d);
      stat(s);
      check(32'(s[4:0]), 32'(k * 4 + 2));
    end
    op(1'b0, 1'b0, 8'h0C, d);
    $display("t_ctrl done");
  endtask : t_ctrl

  task automatic t_data;
    logic [7:0]  d;
    logic [31:0] s;
    op(1'b0, 1'b0, 8'h80, d);
    for (int i = 0; i < 3; i++) op(1'b1, 1'b0, 8'(8'h41 + i), d);
    host.xfer(1'b0, 1'b1, 8'h00, d);
    check(32'(d), 32'h0000_0003);
    op(1'b0, 1'b0, 8'h04, d);
    op(1'b1, 1'b0, 8'h44, d);
    stat(s);
    check(32'(s[14:8]), 32'h0000_0002);
    op(1'b0, 1'b0, 8'h80, d);
    op(1'b0, 1'b0, 8'h06, d);
    for (int i = 0; i < 4; i++) begin
      op(1'b1, 1'b1, 8'h00, d);
      check(32'(d), 32'(8'h41 + i));
    end
    stat(s);
    check(32'(s[14:8]), 32'h0000_0004);
    $display("t_data done");
  endtask : t_data

  task automatic t_shift;
    logic [7:0]  d;
    logic [31:0] s;
    lcdd_scan_t  q;
    op(1'b0, 1'b0, 8'h10, d);
    stat(s);
    check(32'(s[14:8]), 32'h0000_0003);
    op(1'b0, 1'b0, 8'h17, d);
    stat(s);
    check(32'(s[14:8]), 32'h0000_0004);
    op(1'b0, 1'b0, 8'h10, d);
    op(1'b1, 1'b1, 8'h00, d);
    check(32'(d), 32'h0000_0044);
    op(1'b0, 1'b0, 8'h18, d);
    stat(s);
    check(32'({s[19:16], s[14:8]}), 32'h0000_0084);
    scan(4'h0, 3'h0, q);
    check(32'(q.char_code), 32'h0000_0042);
    op(1'b0, 1'b0, 8'h1C, d);
    scan(4'h0, 3'h0, q);
    check(32'(q.char_code), 32'h0000_0041);
    $display("t_shift done");
  endtask : t_shift

  task automatic t_off;
    logic [7:0] d;
    lcdd_scan_t q;
    op(1'b0, 1'b0, 8'h08, d);
    scan(4'h1, 3'h0, q);
    check(32'(q.blank), 32'h0000_0001);
    op(1'b0, 1'b0, 8'h0C, d);
    scan(4'h1, 3'h0, q);
    check(32'({q.blank, q.char_code}), 32'h0000_0042);
    $display("t_off done");
  endtask : t_off

  task automatic t_cursor;
    logic [7:0] d;
    lcdd_scan_t q;
    logic       hi, lo;
    op(1'b0, 1'b0, 8'h82, d);
    op(1'b0, 1'b0, 8'h0E, d);
    scan(4'h2, 3'h7, q);
    check(32'(q.overlay), 32'h0000_001F);
    scan(4'h2, 3'h6, q);
    check(32'(q.overlay), 32'h0000_0000);
    scan(4'h3, 3'h7, q);
    check(32'(q.overlay), 32'h0000_0000);
    op(1'b0, 1'b0, 8'h0D, d);
    scan(4'h2, 3'h0, q);
    hi = 1'b0;
    lo = 1'b0;
    repeat (40) begin
      @(posedge clk);
      if (scan_q.overlay === 5'h1F) hi = 1'b1;
      if (scan_q.overlay === 5'h00) lo = 1'b1;
    end
    check(32'({hi, lo}), 32'h0000_0003);
    $display("t_cursor done");
  endtask : t_cursor

  task automatic t_entry;
    logic [7:0]  d;
    logic [31:0] s;
    op(1'b0, 1'b0, 8'h07, d);
    op(1'b0, 1'b0, 8'h85, d);
    op(1'b1, 1'b0, 8'h46, d);
    stat(s);
    check(32'({s[19:16], s[14:8]}), 32'h0000_0086);
    op(1'b0, 1'b0, 8'h85, d);
    op(1'b1, 1'b1, 8'h00, d);
    check(32'(d), 32'h0000_0046);
    stat(s);
    check(32'({s[19:16], s[14:8]}), 32'h0000_0086);
    $display("t_entry done");
  endtask : t_entry

  task automatic t_map;
    logic [7:0] d;
    logic [6:0] a [4] = '{CG_FIRST, CG_LAST, MK_FIRST, MK_LAST};
    for (int i = 0; i < 4; i++) begin
      op(1'b0, 1'b0, {1'b1, a[i]}, d);
      op(1'b1, 1'b0, 8'(8'h0A + i), d);
      op(1'b0, 1'b0, {1'b1, a[i]}, d);
      op(1'b1, 1'b1, 8'h00, d);
      check(32'(d[4:0]), 32'(5'h0A + i));
    end
    $display("t_map done");
  endtask : t_map

  task automatic t_refuse;
    logic [7:0]  d;
    logic [31:0] s;
    logic        e;
    apb(1'b1, OFS_CTRL, 32'h0000_0000, s, e);
    host.xfer(1'b0, 1'b0, 8'h08, d);
    repeat (10) @(posedge clk);
    stat(s);
    check(32'(s[4]), 32'h0000_0001);
    apb(1'b1, OFS_CTRL, 32'h0000_0001, s, e);
    host.xfer(1'b0, 1'b0, 8'h08, d);
    op(1'b0, 1'b0, 8'h0C, d);
    stat(s);
    check(32'(s[4]), 32'h0000_0000);
    $display("t_refuse done");
  endtask : t_refuse

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    scan_col = 4'h0;
    scan_line = 3'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset;
    t_ctrl;
    t_data;
    t_shift;
    t_off;
    t_cursor;
    t_entry;
    t_map;
    t_refuse;
    results;
  end
endmodule : lcdd_top_tb
